// ---- hdl/partner_page_pkg.sv ----
package partner_page_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] OFFS_LOW  = 16'h0205;
  localparam logic [15:0] OFFS_MID  = 16'h0206;
  localparam logic [15:0] OFFS_HIGH = 16'h0207;
  localparam logic [15:0] OFFS_RES  = 16'h020C;

  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ****************************************
  // field positions, low word
  // ****************************************
  localparam int POS_NEXT_PAGE = 15;
  localparam int POS_ACK       = 14;
  localparam int POS_FAULT     = 13;
  localparam int POS_FORCED    = 12;
  localparam int POS_PAUSE_HI  = 11;
  localparam int POS_PAUSE_LO  = 10;
  localparam int POS_SEL_HI    = 4;

  // ****************************************
  // field positions, middle word
  // ****************************************
  localparam int POS_LONG_REACH = 14;
  localparam int POS_GIGABIT    = 7;
  localparam int POS_SR_FULL    = 6;
  localparam int POS_FAST       = 5;
  localparam int POS_MASTER     = 4;

  // ****************************************
  // field positions, high word
  // ****************************************
  localparam int POS_ENERGY    = 14;
  localparam int POS_HI_ABLE   = 13;
  localparam int POS_HI_REQ    = 12;
  localparam int POS_SR_HALF   = 11;

  localparam logic [15:0] MASK_LOW  = 16'hFC1F;
  localparam logic [15:0] MASK_MID  = 16'h40F0;
  localparam logic [15:0] MASK_HIGH = 16'h7800;

endpackage : partner_page_pkg

// ---- hdl/page_word_hold.sv ----
`timescale 1ns/10ps
module page_word_hold
  import partner_page_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        load_live_i,
  input  wire logic [15:0] live_word_i,
  input  wire logic        snap_i,
  input  wire logic [15:0] mask_i,
  output logic      [15:0] live_o,
  output logic      [15:0] held_o
);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      live_o <= RESET_WORD;
    else if (load_live_i)
      live_o <= live_word_i & mask_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      held_o <= RESET_WORD;
    else if (snap_i)
      held_o <= live_o;
  end

endmodule : page_word_hold

// ---- hdl/partner_base_page_capture.sv ----
`timescale 1ns/10ps
module partner_base_page_capture
  import partner_page_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        page_valid_i,
  input  wire logic [47:0] page_word_i,
  input  wire logic        local_high_level_able_i,
  input  wire logic        local_high_level_request_i,
  output logic             high_level_sel_o,
  output logic             partner_is_master_o,
  output logic             partner_role_forced_o
);

  // ****************************************
  // live capture and snapshots
  // ****************************************
  logic [15:0] live_low;
  logic [15:0] live_mid;
  logic [15:0] live_high;
  logic [15:0] held_mid;
  logic [15:0] held_high;
  logic        snap;
  logic [15:0] rdata_nxt;
  logic        sel_nxt;
  logic        wr_seen_r;

  // ****************************************
  // named fields and decode
  // ****************************************
  logic        low_next_page;
  logic        low_ack;
  logic        low_fault;
  logic        partner_role_forced;
  logic [1:0]  low_pause;
  logic [4:0]  low_selector;
  logic        partner_long_reach_able;
  logic        partner_gigabit_able;
  logic        partner_short_reach_full_duplex;
  logic        partner_fast_able;
  logic        partner_is_master;
  logic        partner_energy_saving_able;
  logic        partner_high_level_able;
  logic        partner_high_level_request;
  logic        partner_short_reach_half_duplex;
  logic        live_is_master;
  logic        live_high_level_able;
  logic        live_high_level_request;
  logic        both_able;
  logic        any_request;
  logic [15:0] low_view;
  logic [15:0] mid_view;
  logic [15:0] high_view;
  logic        hit_low;
  logic        hit_mid;
  logic        hit_high;

  // ****************************************
  // address decode
  // ****************************************
  // one decode shared by the snapshot strobe and the read mux
  assign hit_low  = (reg_addr_i == OFFS_LOW);
  assign hit_mid  = (reg_addr_i == OFFS_MID);
  assign hit_high = (reg_addr_i == OFFS_HIGH);

  // the low word is read live; the snapshot protects only the upper two
  assign snap = reg_rd_i && hit_low;

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      live_low <= RESET_WORD;
    end
    else if (page_valid_i)
    begin
      live_low <= page_word_i[15:0] & MASK_LOW;
    end
  end

  // bit positions of the codeword match the register fields one to one
  page_word_hold u_mid
  (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .load_live_i (page_valid_i),
    .live_word_i (page_word_i[31:16]),
    .snap_i      (snap),
    .mask_i      (MASK_MID),
    .live_o      (live_mid),
    .held_o      (held_mid)
  );

  page_word_hold u_high
  (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .load_live_i (page_valid_i),
    .live_word_i (page_word_i[47:32]),
    .snap_i      (snap),
    .mask_i      (MASK_HIGH),
    .live_o      (live_high),
    .held_o      (held_high)
  );

  // ****************************************
  // field extraction
  // ****************************************
  // the low word is live, so its fields come straight from the capture
  assign low_next_page       = live_low[POS_NEXT_PAGE];
  assign low_ack             = live_low[POS_ACK];
  assign low_fault           = live_low[POS_FAULT];
  assign partner_role_forced = live_low[POS_FORCED];
  assign low_pause           = live_low[POS_PAUSE_HI:POS_PAUSE_LO];
  assign low_selector        = live_low[POS_SEL_HI:0];

  // middle and high fields for the read port come from the held copy
  assign partner_long_reach_able         = held_mid[POS_LONG_REACH];
  assign partner_gigabit_able            = held_mid[POS_GIGABIT];
  assign partner_short_reach_full_duplex = held_mid[POS_SR_FULL];
  assign partner_fast_able               = held_mid[POS_FAST];
  assign partner_is_master               = held_mid[POS_MASTER];
  assign partner_energy_saving_able      = held_high[POS_ENERGY];
  assign partner_high_level_able         = held_high[POS_HI_ABLE];
  assign partner_high_level_request      = held_high[POS_HI_REQ];
  assign partner_short_reach_half_duplex = held_high[POS_SR_HALF];

  // status pins follow the live words so the line side sees each page at once
  assign live_is_master          = live_mid[POS_MASTER];
  assign live_high_level_able    = live_high[POS_HI_ABLE];
  assign live_high_level_request = live_high[POS_HI_REQ];

  // ****************************************
  // read word assembly
  // ****************************************
  // reserved positions are never assigned, so they read as zero
  always_comb
  begin
    low_view                            = RESET_WORD;
    low_view[POS_NEXT_PAGE]             = low_next_page;
    low_view[POS_ACK]                   = low_ack;
    low_view[POS_FAULT]                 = low_fault;
    low_view[POS_FORCED]                = partner_role_forced;
    low_view[POS_PAUSE_HI:POS_PAUSE_LO] = low_pause;
    low_view[POS_SEL_HI:0]              = low_selector;
  end

  always_comb
  begin
    mid_view                 = RESET_WORD;
    mid_view[POS_LONG_REACH] = partner_long_reach_able;
    mid_view[POS_GIGABIT]    = partner_gigabit_able;
    mid_view[POS_SR_FULL]    = partner_short_reach_full_duplex;
    mid_view[POS_FAST]       = partner_fast_able;
    mid_view[POS_MASTER]     = partner_is_master;
  end

  always_comb
  begin
    high_view              = RESET_WORD;
    high_view[POS_ENERGY]  = partner_energy_saving_able;
    high_view[POS_HI_ABLE] = partner_high_level_able;
    high_view[POS_HI_REQ]  = partner_high_level_request;
    high_view[POS_SR_HALF] = partner_short_reach_half_duplex;
  end

  // ****************************************
  // register read port
  // ****************************************
  always_comb
  begin
    rdata_nxt = RESET_WORD;
    if (hit_low)
    begin
      rdata_nxt = low_view;
    end
    else if (hit_mid)
    begin
      rdata_nxt = mid_view;
    end
    else if (hit_high)
    begin
      rdata_nxt = high_view;
    end
    else
    begin
      rdata_nxt = RESET_WORD;
    end
  end

  // the read word stands for one cycle per read, and returns to zero in any cycle without a read
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= RESET_WORD;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rdata_nxt;
    end
    else
    begin
      reg_rdata_o <= RESET_WORD;
    end
  end

  // ****************************************
  // write port
  // ****************************************
  // writes are accepted and dropped; every register here is read-only
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_seen_r <= 1'b0;
    end
    else
    begin
      wr_seen_r <= reg_wr_i & (|reg_wdata_i) & 1'b0;
    end
  end

  // ****************************************
  // transmit level resolution
  // ****************************************
  // either side lacking the high level forces the low level on both
  assign both_able   = local_high_level_able_i && live_high_level_able;
  assign any_request = local_high_level_request_i || live_high_level_request;

  always_comb
  begin
    if (!both_able)
    begin
      sel_nxt = 1'b0;
    end
    else
    begin
      sel_nxt = any_request;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      high_level_sel_o <= 1'b0;
    end
    else
    begin
      high_level_sel_o <= sel_nxt;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      partner_is_master_o <= 1'b0;
    end
    else
    begin
      partner_is_master_o <= live_is_master;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      partner_role_forced_o <= 1'b0;
    end
    else
    begin
      partner_role_forced_o <= partner_role_forced;
    end
  end

endmodule : partner_base_page_capture

// ---- bench/page_props.sv ----
`timescale 1ns/10ps
module page_props
  import partner_page_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        page_valid_i,
  input wire logic [47:0] page_word_i,
  input wire logic        local_high_level_able_i,
  input wire logic        local_high_level_request_i,
  input wire logic        high_level_sel_o,
  input wire logic        partner_is_master_o,
  input wire logic        partner_role_forced_o
);
  // ****
  // read port and status checks
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire lo = reg_rd_i && reg_addr_i == OFFS_LOW;
  wire mi = reg_rd_i && reg_addr_i == OFFS_MID;
  wire hi = reg_rd_i && reg_addr_i == OFFS_HIGH;
  a_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("idle");
  a_low_mask: assert property ($past(lo) |-> !(reg_rdata_o & ~MASK_LOW))
    else $error("low");
  a_mid_mask: assert property ($past(mi) |-> !(reg_rdata_o & ~MASK_MID))
    else $error("mid");
  a_high_mask: assert property ($past(hi) |-> !(reg_rdata_o & ~MASK_HIGH))
    else $error("high");
  a_snap_hold: assert property ($past(mi) && $past(mi, 2) |-> $stable(reg_rdata_o))
    else $error("snap");
  a_role_live: assert property ($past(page_valid_i, 2) |->
    partner_is_master_o == $past(page_word_i[20], 2)) else $error("role");
  a_force_live: assert property ($past(page_valid_i, 2) |->
    partner_role_forced_o == $past(page_word_i[12], 2)) else $error("forced");
  a_level_pick: assert property ($past(page_valid_i, 2) |-> high_level_sel_o ==
    ($past(page_word_i[45], 2) && $past(local_high_level_able_i) &&
    ($past(page_word_i[44], 2) || $past(local_high_level_request_i)))) else $error("level");
endmodule : page_props
bind partner_base_page_capture page_props u_page_props (
  .core_clk_i                 (core_clk_i),
  .rst_n_i                    (rst_n_i),
  .reg_addr_i                 (reg_addr_i),
  .reg_rd_i                   (reg_rd_i),
  .reg_rdata_o                (reg_rdata_o),
  .page_valid_i               (page_valid_i),
  .page_word_i                (page_word_i),
  .local_high_level_able_i    (local_high_level_able_i),
  .local_high_level_request_i (local_high_level_request_i),
  .high_level_sel_o           (high_level_sel_o),
  .partner_is_master_o        (partner_is_master_o),
  .partner_role_forced_o      (partner_role_forced_o));

// ---- bench/page_sender.sv ----
`timescale 1ns/10ps
module page_sender
(
  input  wire logic        core_clk_i,
  input  wire logic        go_i,
  input  wire logic [47:0] word_i,
  output logic             page_valid_o = 1'h0,
  output logic      [47:0] page_word_o = 48'h0
);
  // ****
  // remote codeword source
  // ****
  // idle bus inverts its word on every cycle, so stale data cannot pass
  always_ff @(posedge core_clk_i)
  begin
    page_valid_o <= go_i;
    page_word_o  <= go_i ? word_i : ~page_word_o;
  end
endmodule : page_sender

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench
  import partner_page_pkg::*;
;
  // ****
  // stimulus and scoreboard
  // ****
  logic        core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, page_valid_i, go;
  logic        pend = 1'h0;
  logic        local_high_level_able_i, local_high_level_request_i;
  logic        high_level_sel_o, partner_is_master_o, partner_role_forced_o;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, sm, sh, q[$];
  logic [47:0] page_word_i, wd;
  logic [63:0] x;
  logic [31:0] s = 32'h9045;
  int          mismatches = 0, total_checks = 0;
  partner_base_page_capture u_partner_base_page_capture (.*);
  page_sender u_page_sender (.core_clk_i, .go_i(go), .word_i(wd),
    .page_valid_o(page_valid_i), .page_word_o(page_word_i));
  function automatic logic [31:0] rnd();
    s = {s[30:0], ^(s & 32'h80200003)};
    return s;
  endfunction : rnd
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task bus(input logic w, input logic [15:0] a, input logic [15:0] e);
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    reg_addr_i  <= a;
    reg_wdata_i <= x[15:0];
    if (!w)
      q.push_back(e);
    @(posedge core_clk_i);
  endtask : bus
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    core_clk_i = 1'h0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    if (pend)
      chk("rdata", q.pop_front(), reg_rdata_o);
    pend <= reg_rd_i;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk_i);
    mismatches++;
    end_sim;
  end
  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, go, reg_addr_i, reg_wdata_i, wd, sm, sh, x} = '0;
    {local_high_level_able_i, local_high_level_request_i} = '0;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    for (int i = 0; i < 12; i++)
    begin
      x = {rnd(), rnd()};
      go <= 1'h1;
      wd <= x[47:0];
      local_high_level_able_i <= x[63];
      local_high_level_request_i <= x[62];
      bus(0, OFFS_MID, sm);
      go <= 1'h0;
      bus(0, OFFS_MID, sm);
      bus(0, OFFS_HIGH, sh);
      bus(0, OFFS_LOW, x[15:0] & MASK_LOW);
      sm = x[31:16] & MASK_MID;
      sh = x[47:32] & MASK_HIGH;
      bus(1, OFFS_MID, 16'h0000);
      bus(0, OFFS_MID, sm);
      bus(0, OFFS_HIGH, sh);
      bus(0, OFFS_RES, 16'h0000);
      reg_rd_i <= 1'h0;
      reg_wr_i <= 1'h0;
      repeat (2) @(posedge core_clk_i);
      chk("status", {13'h0, x[20], x[12], x[45] & x[63] & (x[44] | x[62])},
        {13'h0, partner_is_master_o, partner_role_forced_o, high_level_sel_o});
      $display("test %0d done", i);
    end
    end_sim;
  end
endmodule : testbench
